//--- hw/pin_select_map.vh
// Register offsets, field positions, codes and timing for the pin function selector.
// Included by the selector only; holds definitions only.
`ifndef PIN_SELECT_MAP_VH
`define PIN_SELECT_MAP_VH

`define PFS_OFFSET          8'h00
`define PFS_RESET           32'h0000_0000
`define PFS_WRITE_MASK      32'h00FF_FFC0
`define BLINK_CFG_OFFSET    8'h30
`define BLINK_CFG_RESET     8'h20
`define BLINK_CFG_WIDTH     8

`define PIN0_SELECT_LSB     6
`define PIN_SELECT_STRIDE   2
`define PIN_COUNT           9

`define SEL_CODE_GPIO       2'b00
`define SEL_CODE_ALT        2'b01
`define SEL_CODE_CLOCK      2'b10
`define SEL_CODE_SYNC       2'b00
`define SEL_CODE_GPIO_HI    2'b01

`define CLK_PERIOD_NS       40
`define BLINK_UNIT_NS       1000000
`define BLINK_UNIT_CYCLES   (`BLINK_UNIT_NS / `CLK_PERIOD_NS)

`endif

//--- hw/blink_tick.v
// Divides pclk down to one tick pulse per blink time unit.
// Assumes pclk is free running.
`timescale 1ns/1ps
`default_nettype none
module blink_tick #(
  parameter integer UNIT_CYCLES = 25000
) (
  input  wire        pclk,
  input  wire        presetn,
  output reg         tick
);
  reg [31:0] cnt_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (cnt_reg == UNIT_CYCLES - 1) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end
endmodule // blink_tick
`default_nettype wire

//--- hw/blink_stretch.v
// Stretches an event pulse or a level into an LED drive of at least the blink time.
// Assumes tick is a one-cycle pulse per blink time unit.
`timescale 1ns/1ps
`default_nettype none
module blink_stretch #(
  parameter integer TW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          trig,
  input  wire          hold,
  input  wire          tick,
  input  wire [TW-1:0] blink_time,
  output reg           led
);
  reg [TW-1:0] cnt_reg;
  reg          phase_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= {TW{1'b0}};
      phase_reg <= 1'b0;
      led       <= 1'b0;
    end else begin
      // Reload while active so the off delay starts when the source ends
      // First tick after a reload only closes the partial unit, so the on time never undercuts the blink time
      if (trig || hold) begin
        cnt_reg   <= blink_time;
        phase_reg <= 1'b1;
      end else if (tick && phase_reg) begin
        phase_reg <= 1'b0;
      end else if (tick && cnt_reg != {TW{1'b0}}) begin
        cnt_reg <= cnt_reg - {{(TW-1){1'b0}}, 1'b1};
      end
      led <= trig | hold | (cnt_reg != {TW{1'b0}});
    end
  end
endmodule // blink_stretch
`default_nettype wire

//--- hw/gpio_pin_function_select.v
// Pin function selector: APB select and blink registers plus routing of nine multipurpose pins.
// Assumes event inputs are one-cycle pulses and all inputs are synchronous to pclk.
//
// Functional notes
// R01: Pin 0 field bits 7:6: 00 GPIO, 01 receive-good LED, 10 system clock.
// R02: Receive-good LED pulses per good-checksum frame for the blink time.
// R03: Pin 1 field bits 9:8: 00 GPIO, 01 frame-delimiter LED.
// R04: Frame-delimiter LED pulses on each delimiter detection for the blink time.
// R05: Pin 2 field bits 11:10: 00 GPIO, 01 receiver-active LED.
// R06: Receiver LED lit while receiver on, plus at least blink time after.
// R07: Pin 3 field bits 13:12: 00 GPIO, 01 transmit LED.
// R08: Transmit LED pulses per sent frame for the blink time.
// R09: Pin 4 field bits 15:14: 00 GPIO, 01 amplifier control output.
// R10: Pin 5 field bits 17:16: 00 GPIO, 01 external transmit enable.
// R11: Pin 6 field bits 19:18: 00 GPIO, 01 external receive enable.
// R12: Pin 7 field bits 21:20: 00 sync input, 01 GPIO.
// R13: Pin 8 field bits 23:22: 00 interrupt output, 01 GPIO.
// R14: Software writes zero to reserved bits 5:0 and 31:24.
// R15: Software never writes reserved select codes.
// R16: Direction setting applies only to pins in GPIO mode.
// R17: Alternate pins ignore GPIO data; new routing acts one edge after write.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.vh"
module gpio_pin_function_select #(
  parameter integer BLINK_UNIT_CYCLES = `BLINK_UNIT_CYCLES,
  parameter integer NPIN              = `PIN_COUNT
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire [NPIN-1:0] gpio_dir,
  input  wire [NPIN-1:0] gpio_dout,
  output reg  [NPIN-1:0] gpio_din,
  input  wire            rx_frame_good,
  input  wire            rx_sfd_detect,
  input  wire            rx_on,
  input  wire            tx_frame_done,
  input  wire            sys_clock_tap,
  input  wire            amp_ctrl_src,
  input  wire            tx_enable_src,
  input  wire            rx_enable_src,
  input  wire            irq_src,
  output reg             sync_in,
  input  wire [NPIN-1:0] pad_in,
  output reg  [NPIN-1:0] pad_out,
  output reg  [NPIN-1:0] pad_oe,
  output reg             receive_good_led,
  output reg             frame_delimiter_led,
  output reg             receiver_active_led,
  output reg             transmit_led
);

  // Select code of one pin out of the selection register
  function [1:0] pin_sel;
    input [31:0] sel_word;
    input integer pin;
    begin
      pin_sel = sel_word[`PIN0_SELECT_LSB + `PIN_SELECT_STRIDE*pin +: 2];
    end
  endfunction

  reg  [31:0]                 pin_function_select_reg;
  reg  [`BLINK_CFG_WIDTH-1:0] led_blink_config_reg;
  wire                        tick;
  wire [3:0]                  led_drive;

  wire setup_ok = psel && penable && !pready;
  wire wr_done  = psel && penable && pready && pwrite;
  wire hit_pfs  = (paddr == `PFS_OFFSET);
  wire hit_blk  = (paddr == `BLINK_CFG_OFFSET);

  // APB slave: one wait state, answer registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ok;
      pslverr <= setup_ok && !hit_pfs && !hit_blk;
      if (setup_ok && !pwrite && hit_pfs)
        prdata <= pin_function_select_reg;
      else if (setup_ok && !pwrite && hit_blk)
        prdata <= {{(32-`BLINK_CFG_WIDTH){1'b0}}, led_blink_config_reg};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Reserved bits are not stored and read back as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function_select_reg <= `PFS_RESET;
      led_blink_config_reg    <= `BLINK_CFG_RESET;
    end else if (wr_done && hit_pfs) begin
      pin_function_select_reg <= pwdata & `PFS_WRITE_MASK; // R14
    end else if (wr_done && hit_blk) begin
      led_blink_config_reg <= pwdata[`BLINK_CFG_WIDTH-1:0];
    end
  end

  blink_tick #(
    .UNIT_CYCLES (BLINK_UNIT_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  blink_stretch #(.TW(`BLINK_CFG_WIDTH)) u_led_rxok (
    .pclk       (pclk),
    .presetn    (presetn),
    .trig       (rx_frame_good), // R02
    .hold       (1'b0),
    .tick       (tick),
    .blink_time (led_blink_config_reg),
    .led        (led_drive[0])
  );

  blink_stretch #(.TW(`BLINK_CFG_WIDTH)) u_led_sfd (
    .pclk       (pclk),
    .presetn    (presetn),
    .trig       (rx_sfd_detect), // R04
    .hold       (1'b0),
    .tick       (tick),
    .blink_time (led_blink_config_reg),
    .led        (led_drive[1])
  );

  blink_stretch #(.TW(`BLINK_CFG_WIDTH)) u_led_rx (
    .pclk       (pclk),
    .presetn    (presetn),
    .trig       (1'b0),
    .hold       (rx_on), // R06
    .tick       (tick),
    .blink_time (led_blink_config_reg),
    .led        (led_drive[2])
  );

  blink_stretch #(.TW(`BLINK_CFG_WIDTH)) u_led_tx (
    .pclk       (pclk),
    .presetn    (presetn),
    .trig       (tx_frame_done), // R08
    .hold       (1'b0),
    .tick       (tick),
    .blink_time (led_blink_config_reg),
    .led        (led_drive[3])
  );

  // Alternate function selection per pin
  reg [NPIN-1:0] alt_on;
  reg [NPIN-1:0] alt_val;
  reg [NPIN-1:0] alt_oe;
  reg [1:0]      s0;

  always @* begin
    alt_on  = {NPIN{1'b0}};
    alt_val = {NPIN{1'b0}};
    alt_oe  = {NPIN{1'b0}};
    s0      = pin_sel(pin_function_select_reg, 0);
    case (s0)
      `SEL_CODE_ALT: begin
        alt_on[0]  = 1'b1; // R01
        alt_val[0] = led_drive[0];
        alt_oe[0]  = 1'b1;
      end
      `SEL_CODE_CLOCK: begin
        alt_on[0]  = 1'b1; // R01
        alt_val[0] = sys_clock_tap;
        alt_oe[0]  = 1'b1;
      end
      default: begin
        alt_on[0]  = 1'b0;
      end
    endcase
    // Codes 10 and 11 on pins 1 to 6 fall back to GPIO
    case (pin_sel(pin_function_select_reg, 1))
      `SEL_CODE_ALT: begin
        alt_on[1]  = 1'b1; // R03
        alt_val[1] = led_drive[1];
        alt_oe[1]  = 1'b1;
      end
      default: begin
        alt_on[1]  = 1'b0;
      end
    endcase
    case (pin_sel(pin_function_select_reg, 2))
      `SEL_CODE_ALT: begin
        alt_on[2]  = 1'b1; // R05
        alt_val[2] = led_drive[2];
        alt_oe[2]  = 1'b1;
      end
      default: begin
        alt_on[2]  = 1'b0;
      end
    endcase
    case (pin_sel(pin_function_select_reg, 3))
      `SEL_CODE_ALT: begin
        alt_on[3]  = 1'b1; // R07
        alt_val[3] = led_drive[3];
        alt_oe[3]  = 1'b1;
      end
      default: begin
        alt_on[3]  = 1'b0;
      end
    endcase
    case (pin_sel(pin_function_select_reg, 4))
      `SEL_CODE_ALT: begin
        alt_on[4]  = 1'b1; // R09
        alt_val[4] = amp_ctrl_src;
        alt_oe[4]  = 1'b1;
      end
      default: begin
        alt_on[4]  = 1'b0;
      end
    endcase
    case (pin_sel(pin_function_select_reg, 5))
      `SEL_CODE_ALT: begin
        alt_on[5]  = 1'b1; // R10
        alt_val[5] = tx_enable_src;
        alt_oe[5]  = 1'b1;
      end
      default: begin
        alt_on[5]  = 1'b0;
      end
    endcase
    case (pin_sel(pin_function_select_reg, 6))
      `SEL_CODE_ALT: begin
        alt_on[6]  = 1'b1; // R11
        alt_val[6] = rx_enable_src;
        alt_oe[6]  = 1'b1;
      end
      default: begin
        alt_on[6]  = 1'b0;
      end
    endcase
    // Pin 7 is the sync input unless switched to GPIO; its driver stays off
    case (pin_sel(pin_function_select_reg, 7))
      `SEL_CODE_GPIO_HI: begin
        alt_on[7]  = 1'b0;
      end
      default: begin
        alt_on[7]  = 1'b1; // R12
        alt_oe[7]  = 1'b0;
      end
    endcase
    case (pin_sel(pin_function_select_reg, 8))
      `SEL_CODE_GPIO_HI: begin
        alt_on[8]  = 1'b0;
      end
      default: begin
        alt_on[8]  = 1'b1; // R13
        alt_val[8] = irq_src;
        alt_oe[8]  = 1'b1;
      end
    endcase
  end

  // Registered pad drive; GPIO data and direction only reach GPIO-mode pins
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out  <= {NPIN{1'b0}};
      pad_oe   <= {NPIN{1'b0}};
      gpio_din <= {NPIN{1'b0}};
      sync_in  <= 1'b0;
    end else begin
      for (i = 0; i < NPIN; i = i + 1) begin
        if (alt_on[i]) begin
          pad_out[i] <= alt_val[i]; // R17
          pad_oe[i]  <= alt_oe[i];
        end else begin
          pad_out[i] <= gpio_dout[i];
          pad_oe[i]  <= ~gpio_dir[i]; // R16
        end
        gpio_din[i] <= alt_on[i] ? 1'b0 : pad_in[i];
      end
      sync_in <= alt_on[7] & pad_in[7]; // R12
    end
  end

  // LED levels seen at the selector boundary, for status and test
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_good_led    <= 1'b0;
      frame_delimiter_led <= 1'b0;
      receiver_active_led <= 1'b0;
      transmit_led        <= 1'b0;
    end else begin
      receive_good_led    <= led_drive[0];
      frame_delimiter_led <= led_drive[1];
      receiver_active_led <= led_drive[2];
      transmit_led        <= led_drive[3];
    end
  end

endmodule // gpio_pin_function_select
`default_nettype wire

//--- dv/pin_select_chk.sv
// Checker for pad routing and LED drives of the pin function selector.
// Assumes it is bound to the selector and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pin_select_chk #(
  parameter integer NPIN = 9
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic            pready,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic            rx_frame_good,
  input wire logic            rx_on,
  input wire logic            tx_frame_done,
  input wire logic            sys_clock_tap,
  input wire logic            amp_ctrl_src,
  input wire logic            irq_src,
  input wire logic            sync_in,
  input wire logic            receive_good_led,
  input wire logic            receiver_active_led,
  input wire logic            transmit_led,
  input wire logic [NPIN-1:0] gpio_dir,
  input wire logic [NPIN-1:0] pad_in,
  input wire logic [NPIN-1:0] pad_out,
  input wire logic [NPIN-1:0] pad_oe
);
  logic [31:0] s;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the stored select word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      s <= 32'h0000_0000;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      s <= pwdata & 32'h00ff_ffc0;
  end
  clk_out_a: assert property (s[7:6] == 2'b10 |=> pad_oe[0] && pad_out[0] == $past(sys_clock_tap))
    else $error("pin 0 clock routing");
  led_pin_a: assert property (s[7:6] == 2'b01 |=> pad_out[0] == receive_good_led)
    else $error("pin 0 led routing");
  rxok_led_a: assert property (rx_frame_good |-> ##2 receive_good_led)
    else $error("receive led late");
  rx_led_a: assert property (rx_on |-> ##2 receiver_active_led)
    else $error("receiver led off");
  tx_led_a: assert property (tx_frame_done |-> ##2 transmit_led)
    else $error("transmit led late");
  amp_out_a: assert property (s[15:14] == 2'b01 |=> pad_oe[4] && pad_out[4] == $past(amp_ctrl_src))
    else $error("pin 4 routing");
  sync_in_a: assert property (s[21:20] != 2'b01 |=> !pad_oe[7] && sync_in == $past(pad_in[7]))
    else $error("pin 7 sync routing");
  irq_out_a: assert property (s[23:22] != 2'b01 |=> pad_oe[8] && pad_out[8] == $past(irq_src))
    else $error("pin 8 irq routing");
  dir_gpio_a: assert property (s[13:12] == 2'b00 |=> pad_oe[3] == !$past(gpio_dir[3]))
    else $error("pin 3 direction");
endmodule // pin_select_chk
bind gpio_pin_function_select pin_select_chk #(.NPIN(NPIN)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .paddr, .pwdata, .rx_frame_good, .rx_on, .tx_frame_done, .sys_clock_tap, .amp_ctrl_src, .irq_src,
  .sync_in, .receive_good_led, .receiver_active_led, .transmit_led, .gpio_dir, .pad_in, .pad_out, .pad_oe);
`default_nettype wire

//--- dv/pad_far_side.sv
// Far side of the pads: LEDs, amplifier, sync source, host interrupt input.
// Assumes ext is the level an outside source puts on an undriven pin.
`timescale 1ns/1ps
`default_nettype none
module pad_far_side (
  input wire logic [8:0] pad_out,
  input wire logic [8:0] pad_oe,
  input wire logic [8:0] ext,
  output logic     [8:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule // pad_far_side
`default_nettype wire

//--- dv/tb.sv
// Testbench for the pin function selector: APB access, pad routing, LEDs.
// Assumes a blink unit shortened to 4 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_in, er;
  logic rx_frame_good, rx_sfd_detect, rx_on, tx_frame_done;
  logic receive_good_led, frame_delimiter_led, receiver_active_led, transmit_led;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, sel_m;
  logic [8:0] gpio_dir, gpio_dout, gpio_din, pad_in, pad_out, pad_oe, src, ext;
  int fails, total_checks;
  gpio_pin_function_select #(.BLINK_UNIT_CYCLES(4)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .gpio_dir, .gpio_dout, .gpio_din, .rx_frame_good, .rx_sfd_detect,
    .rx_on, .tx_frame_done, .sys_clock_tap(src[0]), .amp_ctrl_src(src[4]), .tx_enable_src(src[5]),
    .rx_enable_src(src[6]), .irq_src(src[8]), .sync_in, .pad_in, .pad_out, .pad_oe, .receive_good_led,
    .frame_delimiter_led, .receiver_active_led, .transmit_led);
  pad_far_side far (.pad_out, .pad_oe, .ext, .pad_in);
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  task bus(input [7:0] a, input [31:0] d, input w);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Expected pads from the select word, sources and GPIO settings
  task pads;
    int f;
    bit g;
    logic [8:0] eo, ed, cm, ex;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      f = (sel_m >> (6 + 2 * i)) & 3;
      g = (i < 7) ? (f != 1 && !(i == 0 && f == 2)) : (f == 1);
      eo[i] = g ? !gpio_dir[i] : (i != 7);
      ed[i] = g ? (eo[i] ? gpio_dout[i] : ext[i]) : 1'b0;
      cm[i] = eo[i] && (g || i > 3 || f == 2);
      ex[i] = g ? gpio_dout[i] : src[i];
    end
    chk(pad_oe, eo);
    chk(pad_out & cm, ex & cm);
    chk(gpio_din, ed);
    chk(sync_in, (sel_m[21:20] != 2'b01) & ext[7]);
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #200000;
    fails++;
    finish_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rx_frame_good, rx_sfd_detect, rx_on, tx_frame_done} = 0;
    {gpio_dir, gpio_dout, src, ext} = 0;
    void'($urandom(32'h3d29_e87a));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    bus(8'h00, 0, 0);
    chk(rd, 32'h0000_0000);
    bus(8'h30, 0, 0);
    chk(rd, 32'h0000_0020);
    for (int n = 0; n < 14; n++) begin
      {src, gpio_dir, gpio_dout, ext} <= {9'($urandom), 9'($urandom), 9'($urandom), 9'($urandom)};
      sel_m = 0;
      for (int i = 0; i < 9; i++)
        sel_m[6 + 2 * i +: 2] = 2'($urandom_range(i == 0 ? 2 : 1));
      if (n == 0)
        sel_m = 32'h0055_5540;
      if (n == 1)
        sel_m = 32'h0000_0080;
      bus(8'h00, sel_m, 1);
      bus(8'h00, 0, 0);
      chk(rd, sel_m);
      pads;
    end
    bus(8'h00, 32'hff00_003f, 1);
    bus(8'h04, 32'h0000_0040, 1);
    chk(er, 1);
    bus(8'h04, 0, 0);
    chk(rd, 0);
    bus(8'h00, 0, 0);
    chk(rd, 0);
    sel_m = 32'h0000_5540;
    bus(8'h00, sel_m, 1);
    bus(8'h30, 2, 1);
    @(posedge pclk);
    {rx_frame_good, rx_sfd_detect, tx_frame_done, rx_on} <= 4'hf;
    @(posedge pclk);
    {rx_frame_good, rx_sfd_detect, tx_frame_done} <= 3'b000;
    @(posedge pclk);
    #1 chk({receive_good_led, frame_delimiter_led, receiver_active_led, transmit_led, pad_out[3:0]}, 8'hff);
    repeat (7) @(posedge pclk);
    #1 chk({receive_good_led, frame_delimiter_led, receiver_active_led, transmit_led, pad_out[3:0]}, 8'hff);
    @(posedge pclk);
    rx_on <= 0;
    repeat (9) @(posedge pclk);
    #1 chk(receiver_active_led, 1);
    repeat (12) @(posedge pclk);
    #1 chk({receive_good_led, frame_delimiter_led, receiver_active_led, transmit_led, pad_out[3:0]}, 8'h00);
    finish_test;
  end
endmodule // tb
`default_nettype wire
